//--- logic/lrst_reset_init.sv
// Behaviour
// - reset clears vertical scroll line count
// - reset sets window one end 9f, begin 0
// - reset sets window two end 9f, begin 0
// - reset sets horizontal window 7f..00
// - reset sets vertical window 9f..00
// - reset presets ram address counter to zero
// - reset clears all gamma fields
// - accesses refused while hardware reset held
// - reset turns display control off
//
// Decided for this implementation: strobed register access and the address map.
`include "lrst_params.svh"
`timescale 1ns/100ps
module lrst_reset_init
  import lrst_pkg::*;
#(
  parameter int OSC_SETTLE_CYC = (`LRST_OSC_SETTLE_MS * `LRST_NS_PER_MS) / `LRST_CLK_PERIOD_NS,
  parameter int GRAPHICS_RAM_AW = 16,
  parameter int GRAPHICS_RAM_DW = 18
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hw_reset_low,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [17:0] rdata,
  output logic [7:0] scroll_line_count,
  output lrst_span_s win1_span,
  output lrst_span_s win2_span,
  output lrst_span_s hwin_span,
  output lrst_span_s vwin_span,
  output logic [1:0] display_onoff_ctrl,
  output logic [GRAPHICS_RAM_AW-1:0] ram_addr,
  output logic [15:0] gamma_flat [0:11],
  output logic access_ready
);
  lrst_req_s req;
  logic rst_any;
  logic take_wr;
  logic take_rd;
  logic [7:0] scroll_reg;
  lrst_span_s win1_reg;
  lrst_span_s win2_reg;
  lrst_span_s hwin_reg;
  lrst_span_s vwin_reg;
  logic [1:0] disp_reg;
  logic [GRAPHICS_RAM_AW-1:0] ac_reg;
  logic [15:0] gamma_reg [0:11];
  lrst_state_e state_reg;
  logic [31:0] settle_reg;
  logic ram_rd_reg;
  logic [17:0] rdata_reg;
  logic [GRAPHICS_RAM_DW-1:0] graphics_ram_q;
  logic graphics_ram_we;

  function automatic logic is_gamma(input logic [7:0] a);
    logic [3:0] off;
    off = a[3:0];
    is_gamma = (a >= `LRST_IDX_GAMMA_FIRST) && (a <= `LRST_IDX_GAMMA_LAST) &&
               (off != `LRST_GAMMA_OFF_GAP0) && (off != `LRST_GAMMA_OFF_GAP1);
  endfunction

  function automatic logic [15:0] gamma_mask(input logic [3:0] off);
    gamma_mask = ((off == `LRST_GAMMA_OFF_OP) || (off == `LRST_GAMMA_OFF_ON)) ?
                 `LRST_GAMMA_MASK45 : `LRST_GAMMA_MASK3;
  endfunction

  function automatic logic [3:0] gamma_slot(input logic [3:0] off);
    gamma_slot = (off >= `LRST_GAMMA_OFF_OP) ? off - 4'h2 : off;
  endfunction

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign rst_any = !rstn || !hw_reset_low;
  assign take_wr = req.wr && !rst_any;
  assign take_rd = req.rd && !rst_any;
  assign graphics_ram_we = take_wr && (req.addr == `LRST_IDX_RAM_DATA);

  always_ff @(posedge core_clk) begin
    if (rst_any) begin
      scroll_reg <= `LRST_RST_ZERO8;
    end else if (take_wr && req.addr == `LRST_IDX_SCROLL) begin
      scroll_reg <= req.wdata[`LRST_LO_MSB:`LRST_LO_LSB];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_any) begin
      win1_reg <= '{end_pos: `LRST_RST_WIN_END, begin_pos: `LRST_RST_ZERO8};
      win2_reg <= '{end_pos: `LRST_RST_WIN_END, begin_pos: `LRST_RST_ZERO8};
    end else if (take_wr) begin
      if (req.addr == `LRST_IDX_WIN1) begin
        win1_reg <= req.wdata;
      end
      if (req.addr == `LRST_IDX_WIN2) begin
        win2_reg <= req.wdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_any) begin
      hwin_reg <= '{end_pos: `LRST_RST_HWIN_END, begin_pos: `LRST_RST_ZERO8};
      vwin_reg <= '{end_pos: `LRST_RST_WIN_END, begin_pos: `LRST_RST_ZERO8};
    end else if (take_wr) begin
      if (req.addr == `LRST_IDX_HWIN) begin
        hwin_reg <= req.wdata;
      end
      if (req.addr == `LRST_IDX_VWIN) begin
        vwin_reg <= req.wdata;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst_any) begin
      disp_reg <= `LRST_RST_DISP;
    end else if (take_wr && req.addr == `LRST_IDX_DISP_CTRL) begin
      disp_reg <= req.wdata[`LRST_DISP_MSB:`LRST_DISP_LSB];
    end
  end

  // address counter: set by index write, steps after each ram data write
  always_ff @(posedge core_clk) begin
    if (rst_any) begin
      ac_reg <= `LRST_RST_ZERO16;
    end else if (take_wr && req.addr == `LRST_IDX_RAM_ADDR) begin
      ac_reg <= req.wdata;
    end else if (graphics_ram_we) begin
      ac_reg <= ac_reg + GRAPHICS_RAM_AW'(`LRST_ONE);
    end
  end

  genvar gi;
  generate
    for (gi = 0; gi < 12; gi++) begin : g_gamma
      always_ff @(posedge core_clk) begin
        if (rst_any) begin
          gamma_reg[gi] <= `LRST_RST_GAMMA;
        end else if (take_wr && is_gamma(req.addr) && gamma_slot(req.addr[3:0]) == 4'(gi)) begin
          gamma_reg[gi] <= req.wdata & gamma_mask(req.addr[3:0]);
        end
      end
      assign gamma_flat[gi] = gamma_reg[gi];
    end
  endgenerate

  // settle tracking after hardware reset release, shown as status
  always_ff @(posedge core_clk) begin
    if (rst_any) begin
      state_reg <= LRST_HELD;
      settle_reg <= '0;
    end else begin
      unique case (state_reg)
        LRST_HELD: begin
          state_reg <= LRST_SETTLE;
        end
        LRST_SETTLE: begin
          if (settle_reg >= 32'(OSC_SETTLE_CYC - 1)) begin
            state_reg <= LRST_READY;
          end
          settle_reg <= settle_reg + 32'd1;
        end
        LRST_READY: begin
          state_reg <= LRST_READY;
        end
        default: begin
          state_reg <= LRST_HELD;
        end
      endcase
    end
  end

  lrst_graphics_ram #(
    .AW(GRAPHICS_RAM_AW),
    .DW(GRAPHICS_RAM_DW),
    .DEPTH(1 << GRAPHICS_RAM_AW)
  ) u_graphics_ram (
    .core_clk(core_clk),
    .wr_en(graphics_ram_we),
    .addr(ac_reg),
    .wdata({2'b00, req.wdata}),
    .rdata(graphics_ram_q)
  );

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      ram_rd_reg <= 1'b0;
      rdata_reg <= '0;
    end else begin
      ram_rd_reg <= take_rd && (req.addr == `LRST_IDX_RAM_DATA);
      rdata_reg <= '0;
      if (take_rd) begin
        unique case (req.addr)
          `LRST_IDX_DISP_CTRL: rdata_reg <= 18'(disp_reg);
          `LRST_IDX_SCROLL: rdata_reg <= 18'(scroll_reg);
          `LRST_IDX_WIN1: rdata_reg <= 18'(win1_reg);
          `LRST_IDX_WIN2: rdata_reg <= 18'(win2_reg);
          `LRST_IDX_HWIN: rdata_reg <= 18'(hwin_reg);
          `LRST_IDX_VWIN: rdata_reg <= 18'(vwin_reg);
          `LRST_IDX_RAM_ADDR: rdata_reg <= 18'(ac_reg);
          `LRST_IDX_STATUS: rdata_reg <= 18'(state_reg);
          default: begin
            if (is_gamma(req.addr)) begin
              rdata_reg <= 18'(gamma_reg[gamma_slot(req.addr[3:0])]);
            end
          end
        endcase
      end
    end
  end

  assign rdata = ram_rd_reg ? graphics_ram_q : rdata_reg;
  assign scroll_line_count = scroll_reg;
  assign win1_span = win1_reg;
  assign win2_span = win2_reg;
  assign hwin_span = hwin_reg;
  assign vwin_span = vwin_reg;
  assign display_onoff_ctrl = disp_reg;
  assign ram_addr = ac_reg;
  assign access_ready = (state_reg == LRST_READY);
endmodule

//--- logic/lrst_params.svh
`ifndef LRST_PARAMS_SVH
`define LRST_PARAMS_SVH

// register indexes, as printed
`define LRST_IDX_DISP_CTRL 8'h07
`define LRST_IDX_SCROLL 8'h11
`define LRST_IDX_WIN1 8'h14
`define LRST_IDX_WIN2 8'h15
`define LRST_IDX_HWIN 8'h16
`define LRST_IDX_VWIN 8'h17
`define LRST_IDX_RAM_ADDR 8'h21
`define LRST_IDX_RAM_DATA 8'h22
`define LRST_IDX_GAMMA_FIRST 8'h30
`define LRST_IDX_GAMMA_LAST 8'h3b
// own status register
`define LRST_IDX_STATUS 8'h40

// reset values
`define LRST_RST_ZERO8 8'h00
`define LRST_RST_ZERO16 16'h0000
`define LRST_RST_WIN_END 8'h9f
`define LRST_RST_HWIN_END 8'h7f
`define LRST_RST_DISP 2'b00
`define LRST_RST_GAMMA 16'h0000

// field positions
`define LRST_HI_MSB 15
`define LRST_HI_LSB 8
`define LRST_LO_MSB 7
`define LRST_LO_LSB 0
`define LRST_DISP_MSB 1
`define LRST_DISP_LSB 0

// gamma writable bits per index offset (3-bit, 4/5-bit fields)
`define LRST_GAMMA_MASK3 16'h0707
`define LRST_GAMMA_MASK45 16'h1f0f
`define LRST_GAMMA_OFF_OP 4'ha
`define LRST_GAMMA_OFF_ON 4'hb
`define LRST_GAMMA_OFF_GAP0 4'h8
`define LRST_GAMMA_OFF_GAP1 4'h9

// timing, for reference and status
`define LRST_CLK_PERIOD_NS 5
`define LRST_OSC_SETTLE_MS 10
`define LRST_NS_PER_MS 1000000
`define LRST_ONE 1

`endif

//--- logic/lrst_pkg.sv
package lrst_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } lrst_req_s;

  typedef struct packed {
    logic [7:0] end_pos;
    logic [7:0] begin_pos;
  } lrst_span_s;

  typedef enum logic [1:0] {
    LRST_HELD = 2'b00,
    LRST_SETTLE = 2'b01,
    LRST_READY = 2'b10
  } lrst_state_e;
endpackage

//--- logic/lrst_graphics_ram.sv
`timescale 1ns/100ps
module lrst_graphics_ram #(
  parameter int AW = 16,
  parameter int DW = 18,
  parameter int DEPTH = 65536
) (
  input wire logic core_clk,
  input wire logic wr_en,
  input wire logic [AW-1:0] addr,
  input wire logic [DW-1:0] wdata,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [0:DEPTH-1];

  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      mem[addr] <= wdata;
    end
  end

  always_ff @(posedge core_clk) begin
    rdata <= mem[addr];
  end
endmodule

//--- test/lrst_reset_init_monitor.sv
`timescale 1ns/100ps
module lrst_monitor
  import lrst_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic hw_reset_low,
  input wire logic [7:0] addr,
  input wire logic rd,
  input wire logic [17:0] rdata,
  input wire logic [7:0] scroll_line_count,
  input wire lrst_span_s win1_span,
  input wire lrst_span_s win2_span,
  input wire lrst_span_s hwin_span,
  input wire lrst_span_s vwin_span,
  input wire logic [1:0] display_onoff_ctrl,
  input wire logic [15:0] ram_addr,
  input wire logic [15:0] gamma_flat [0:11]
);
  default clocking @(posedge core_clk); endclocking
  wire rst_any = !rstn || !hw_reset_low;
  logic [15:0] gam_or;
  always_comb begin
    gam_or = 16'h0000;
    for (int i = 0; i < 12; i++) gam_or = gam_or | gamma_flat[i];
  end
  property p_scroll; rst_any |=> scroll_line_count == 8'h00; endproperty
  a_scroll: assert property (p_scroll) else $error("scroll not cleared");
  property p_win; rst_any |=> win1_span == 16'h9f00 && win2_span == 16'h9f00; endproperty
  a_win: assert property (p_win) else $error("window default wrong");
  property p_area; rst_any |=> hwin_span == 16'h7f00 && vwin_span == 16'h9f00; endproperty
  a_area: assert property (p_area) else $error("access window default wrong");
  property p_addr; rst_any |=> ram_addr == 16'h0000; endproperty
  a_addr: assert property (p_addr) else $error("address counter not cleared");
  property p_gam; rst_any |=> gam_or == 16'h0000; endproperty
  a_gam: assert property (p_gam) else $error("gamma not cleared");
  property p_disp; rst_any |=> display_onoff_ctrl == 2'b00; endproperty
  a_disp: assert property (p_disp) else $error("display not off");
  property p_refuse; rst_any && rd |=> rdata == 18'h0_0000; endproperty
  a_refuse: assert property (p_refuse) else $error("read served in reset");
  property p_first; disable iff (rst_any) $past(rst_any) && rd && addr == 8'h14 |=> rdata == 18'h0_9f00;
  endproperty
  a_first: assert property (p_first) else $error("first read lacks default");
  c_first: cover property ($past(rst_any) && rd && !rst_any);
  c_rst_rd: cover property (rst_any && rd);
  c_graphics_ram: cover property (!rst_any && rd && addr == 8'h22);
endmodule
bind lrst_reset_init lrst_monitor u_mon (.core_clk(core_clk), .rstn(rstn), .hw_reset_low(hw_reset_low),
  .addr(addr), .rd(rd), .rdata(rdata), .scroll_line_count(scroll_line_count), .win1_span(win1_span),
  .win2_span(win2_span), .hwin_span(hwin_span), .vwin_span(vwin_span),
  .display_onoff_ctrl(display_onoff_ctrl), .ram_addr(ram_addr), .gamma_flat(gamma_flat));

//--- test/lrst_host_model.sv
`timescale 1ns/100ps
module lrst_host (
  input wire logic core_clk,
  output logic hw_reset_low,
  output logic [7:0] addr,
  output logic [15:0] wdata,
  output logic wr,
  output logic rd
);
  initial begin
    hw_reset_low = 1'b0;
    addr = 8'h00;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
  end
  // holds the pin low a scaled-down reset width
  task automatic hold_reset(input int n);
    hw_reset_low <= 1'b0;
    repeat (n) @(posedge core_clk);
    hw_reset_low <= 1'b1;
  endtask
  task automatic access(input logic w, input logic [7:0] a, input logic [15:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge core_clk);
  endtask
  task automatic idle();
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge core_clk);
  endtask
endmodule

//--- test/lrst_reset_init_tb.sv
`timescale 1ns/100ps
module lrst_reset_init_tb
  import lrst_pkg::*;
;
  logic core_clk, rstn, access_ready;
  logic rd_q = 1'b0;
  logic [17:0] rdata, exp_q[$];
  logic [7:0] scl;
  logic [1:0] disp;
  logic [15:0] ram_addr, d, gam [0:11];
  lrst_span_s w1, w2, hw, vw;
  logic [31:0] seed = 32'h0001_0db9;
  int err_total = 0, compares = 0, cyc = 0;
  logic [7:0] ix [8] = '{8'h14, 8'h11, 8'h15, 8'h16, 8'h17, 8'h07, 8'h30, 8'h3b};
  logic [15:0] dv [8] = '{16'h9f00, 16'h0000, 16'h9f00, 16'h7f00, 16'h9f00, 16'h0000, 16'h0000, 16'h0000};
  logic [15:0] mk [8] = '{16'hffff, 16'h00ff, 16'hffff, 16'hffff, 16'hffff, 16'h0003, 16'h0707, 16'h1f0f};
  wire hwr, wr, rd;
  wire [7:0] addr;
  wire [15:0] wdata;
  lrst_host u_host (.core_clk(core_clk), .hw_reset_low(hwr), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
  lrst_reset_init #(.OSC_SETTLE_CYC(8)) u_dut (.core_clk(core_clk), .rstn(rstn), .hw_reset_low(hwr),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .scroll_line_count(scl), .win1_span(w1),
    .win2_span(w2), .hwin_span(hw), .vwin_span(vw), .display_onoff_ctrl(disp), .ram_addr(ram_addr),
    .gamma_flat(gam), .access_ready(access_ready));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic do_rd(input logic [7:0] a, input logic [17:0] exp);
    exp_q.push_back(exp);
    u_host.access(1'b0, a, 16'h0000);
  endtask
  task automatic report_and_stop();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    if (rd_q) cmp(rdata, exp_q.pop_front());
    rd_q <= rd;
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      report_and_stop();
    end
  end
  initial begin
    rstn = 1'b0;
    repeat (5) @(posedge core_clk);
    rstn <= 1'b1;
    u_host.hold_reset(4);
    for (int n = 0; n < 50 && access_ready !== 1'b1; n++) @(posedge core_clk);
    cmp({17'h0_0000, access_ready}, 18'h0_0001);
    do_rd(8'h40, 18'h0_0002);
    for (int i = 0; i < 8; i++) do_rd(ix[i], {2'b00, dv[i]});
    cmp({2'b00, ram_addr}, 18'h0_0000);
    for (int i = 0; i < 8; i++) begin
      seed = xs(seed);
      u_host.access(1'b1, ix[i], seed[15:0]);
      do_rd(ix[i], {2'b00, seed[15:0] & mk[i]});
    end
    u_host.access(1'b1, 8'h38, seed[31:16]);
    do_rd(8'h38, 18'h0_0000);
    d = seed[31:16];
    u_host.access(1'b1, 8'h07, 16'h0000);
    u_host.access(1'b1, 8'h21, d);
    u_host.access(1'b1, 8'h22, seed[15:0]);
    u_host.access(1'b1, 8'h22, d);
    u_host.idle();
    cmp({2'b00, ram_addr}, {2'b00, d + 16'h0002});
    u_host.access(1'b1, 8'h21, d);
    do_rd(8'h22, {2'b00, seed[15:0]});
    u_host.idle();
    repeat (8) @(posedge core_clk);
    repeat (16) @(posedge core_clk);
    u_host.access(1'b1, 8'h07, 16'h0003);
    do_rd(8'h07, 18'h0_0003);
    fork
      u_host.hold_reset(3);
      begin
        u_host.access(1'b1, 8'h14, 16'h1234);
        do_rd(8'h14, 18'h0_0000);
        u_host.idle();
      end
    join
    do_rd(8'h14, 18'h0_9f00);
    do_rd(8'h07, 18'h0_0000);
    u_host.idle();
    repeat (2) @(posedge core_clk);
    report_and_stop();
  end
endmodule
